//--- hw/pio_pad.sv
// Output stage of one bidirectional port: GPIO or alternate source,
// push/pull or open-drain, reset forcing and the always-driven lines.
// Assumes all control inputs but force_in come from flops on the same clock.
`timescale 1ns/1ns
module pio_pad #(
    parameter int          W      = 16,
    parameter logic [15:0] MASK   = 16'hffff,
    parameter logic        HAS_OD = 1'b0,
    parameter logic [15:0] KEEP   = 16'h0000
) (
    input  wire logic [W-1:0] out_val,
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] od,
    input  wire logic [W-1:0] alt_en,
    input  wire logic [W-1:0] alt_out,
    input  wire logic [W-1:0] alt_oe,
    input  wire logic         force_in,
    input  wire logic         keep_val,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe_n
);

    // Per-line source select and driver enable
    always_comb
    begin
        logic val;
        logic en;
        logic odm;
        val = 1'b0;
        en  = 1'b0;
        odm = 1'b0;
        for (int i = 0; i < W; i++)
        begin
            val = alt_en[i] ? alt_out[i] : out_val[i];
            en  = alt_en[i] ? alt_oe[i] : dir[i];
            odm = HAS_OD & od[i];
            if (KEEP[i])
            begin
                // Reset indication stays driven even while in reset
                pin_out[i]  = keep_val;
                pin_oe_n[i] = 1'b0;
            end
            else if (!MASK[i] || force_in || !en)
            begin
                pin_out[i]  = 1'b0;
                pin_oe_n[i] = 1'b1;
            end
            else
            begin
                // Open drain pulls low only, releases for a one
                pin_out[i]  = val & ~odm;
                pin_oe_n[i] = odm & val;
            end
        end
    end

endmodule

//--- hw/pio_sync.sv
// Two-stage synchroniser for a vector of pin levels.
// Assumes each bit is an independent level from outside the pclk domain.
`timescale 1ns/1ns
module pio_sync #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

//--- hw/pio_top.sv
// Parallel port block: register file on APB, pin synchronisers and
// one output stage per bidirectional port.
// Assumes pins arrive asynchronously; peripherals share pclk.
`timescale 1ns/1ns
module pio_top (
    // APB side
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic      [31:0]          prdata,
    output logic                      pslverr,
    // Pads
    input  wire logic [6:0][15:0]     pin_in,
    output logic      [5:0][15:0]     pin_out,
    output logic      [5:0][15:0]     pin_oe_n,
    // Peripherals
    input  wire logic [5:0][15:0]     alt_out,
    input  wire logic [5:0][15:0]     alt_oe,
    output logic      [6:0][15:0]     alt_in,
    // Pad controls and strap
    output logic      [5:0][3:0]      pad_driver_control,
    output logic      [6:0][1:0]      threshold_sel,
    output logic                      external_access_enable
);

    // ************************************************************
    // Declarations
    // ************************************************************
    // Pin samples
    logic [6:0][15:0] pin_sync;

    // Port configuration
    logic [5:0][15:0] out_q;
    logic [5:0][15:0] out_d;
    logic [5:0][15:0] dir_q;
    logic [5:0][15:0] dir_d;
    logic [5:0][15:0] od_q;
    logic [5:0][15:0] od_d;
    logic [5:0][15:0] alt_q;
    logic [5:0][15:0] alt_d;
    logic [5:0][3:0]  pad_q;
    logic [5:0][3:0]  pad_d;
    logic [6:0][1:0]  thr_q;
    logic [6:0][1:0]  thr_d;

    // Reset indication release
    logic             init_done_q;
    logic             init_done_d;

    // Bus answer
    logic             ack_q;
    logic             ack_d;
    logic [31:0]      prdata_q;
    logic [31:0]      prdata_d;
    logic             pslverr_q;
    logic             pslverr_d;

    // Address decode
    logic [2:0]       a_port;
    logic [3:0]       a_reg;
    logic             a_ok;
    logic             wr_take;

    // ************************************************************
    // Helpers
    // ************************************************************

    // Whether a port slot and register index name a real register
    function automatic logic reg_ok(input logic [2:0] port, input logic [3:0] r);
        logic ok;
        ok = 1'b0;
        // Unlisted slots are refused
        if (port == pio_pkg::CTRL_PORT)
            ok = (r == pio_pkg::REG_CTRL);
        else if (port == 3'(pio_pkg::NBIDIR))
            ok = (r == pio_pkg::REG_IN) || (r == pio_pkg::REG_THR && pio_pkg::THR_CAP[port]);
        else
        begin
            case (r)
                pio_pkg::REG_OUT, pio_pkg::REG_DIR, pio_pkg::REG_IN,
                pio_pkg::REG_SET, pio_pkg::REG_CLR, pio_pkg::REG_ALT,
                pio_pkg::REG_PAD: ok = 1'b1;
                // Capability differs per port
                pio_pkg::REG_OD:  ok = pio_pkg::OD_CAP[port];
                pio_pkg::REG_THR: ok = pio_pkg::THR_CAP[port];
                default:          ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

    // Widen a port slice to a bus word, upper bits zero
    function automatic logic [31:0] word16(input logic [15:0] v);
        return {16'h0000, v};
    endfunction

    // ************************************************************
    // Input synchronisation
    // ************************************************************

    // Every pin is sampled, whatever its direction
    // Costs two cycles of latency, avoids metastability
    pio_sync #(
        .W (pio_pkg::NPORT * pio_pkg::PW)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (pin_in),
        .q     (pin_sync)
    );

    // Synchronised levels to peripherals; lines beyond a port read zero
    always_comb
    begin
        for (int p = 0; p < pio_pkg::NPORT; p++)
            alt_in[p] = pin_sync[p] & pio_pkg::PORT_MASK[p];
    end

    // Strap level, already synchronised
    assign external_access_enable =
        pin_sync[pio_pkg::P20_IDX][pio_pkg::P20_EXTERNAL_ACCESS_BIT];

    // ************************************************************
    // APB decode
    // ************************************************************

    // Port slot [8:6], register index [5:2]
    assign a_port  = paddr[pio_pkg::ADDR_PORT_LSB +: 3];
    assign a_reg   = paddr[pio_pkg::ADDR_REG_LSB +: 4];
    assign a_ok    = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0) && reg_ok(a_port, a_reg);
    // Writes land only at the edge where pready is seen high
    assign wr_take = psel && penable && ack_q && pwrite && a_ok;

    // Handshake: one wait state so read data come from a flop
    always_comb
    begin
        ack_d     = psel && penable && !ack_q;
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        // Refused reads return zero
        if (psel && penable && !ack_q)
        begin
            pslverr_d = !a_ok;
            prdata_d  = 32'h0000_0000;
            if (a_ok && !pwrite)
            begin
                // Control slot has no port slice
                if (a_port == pio_pkg::CTRL_PORT)
                    prdata_d = {31'h0, init_done_q};
                else if (a_reg == pio_pkg::REG_IN)
                    prdata_d = word16(alt_in[a_port]);
                else if (a_reg == pio_pkg::REG_THR)
                    prdata_d = {30'h0, thr_q[a_port]};
                else
                begin
                    case (a_reg)
                        pio_pkg::REG_OUT,
                        pio_pkg::REG_SET,
                        pio_pkg::REG_CLR: prdata_d = word16(out_q[a_port]);
                        pio_pkg::REG_DIR: prdata_d = word16(dir_q[a_port]);
                        pio_pkg::REG_OD:  prdata_d = word16(od_q[a_port]);
                        pio_pkg::REG_ALT: prdata_d = word16(alt_q[a_port]);
                        pio_pkg::REG_PAD: prdata_d = {28'h000_0000, pad_q[a_port]};
                        default:          prdata_d = 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // Handshake registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ack_q     <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            ack_q     <= ack_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Straight from flops, no decode glitches
    assign pready  = ack_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // ************************************************************
    // Port configuration registers
    // ************************************************************

    // Next values from register writes; bits outside a port stay zero
    always_comb
    begin
        logic [15:0] m;
        m           = 16'h0000;
        out_d       = out_q;
        dir_d       = dir_q;
        od_d        = od_q;
        alt_d       = alt_q;
        pad_d       = pad_q;
        thr_d       = thr_q;
        init_done_d = init_done_q;
        // Refused writes change nothing
        if (wr_take)
        begin
            // Lines beyond the port stay zero
            m = pio_pkg::PORT_MASK[a_port[2:0]];
            if (a_port == pio_pkg::CTRL_PORT)
                init_done_d = pwdata[0];
            else if (a_reg == pio_pkg::REG_THR)
                thr_d[a_port] = pwdata[1:0];
            else if (a_port < 3'(pio_pkg::NBIDIR))
            begin
                case (a_reg)
                    pio_pkg::REG_OUT: out_d[a_port] = pwdata[15:0] & m;
                    // Set and clear touch only the lines written as one
                    pio_pkg::REG_SET: out_d[a_port] = out_q[a_port] | (pwdata[15:0] & m);
                    pio_pkg::REG_CLR: out_d[a_port] = out_q[a_port] & ~pwdata[15:0];
                    pio_pkg::REG_DIR: dir_d[a_port] = pwdata[15:0] & m;
                    pio_pkg::REG_OD:  od_d[a_port]  = pwdata[15:0] & m;
                    pio_pkg::REG_ALT: alt_d[a_port] = pwdata[15:0] & m;
                    pio_pkg::REG_PAD: pad_d[a_port] = pwdata[3:0];
                    default:          out_d[a_port] = out_q[a_port];
                endcase
            end
        end
    end

    // Reset leaves every line but the P20 reset indication an input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_q       <= {pio_pkg::NBIDIR{pio_pkg::OUT_RST}};
            dir_q       <= {pio_pkg::NBIDIR{pio_pkg::DIR_RST}};
            od_q        <= {pio_pkg::NBIDIR{pio_pkg::OD_RST}};
            alt_q       <= {pio_pkg::NBIDIR{pio_pkg::ALT_RST}};
            pad_q       <= {pio_pkg::NBIDIR{pio_pkg::PAD_RST}};
            thr_q       <= {pio_pkg::NPORT{pio_pkg::THR_RST}};
            init_done_q <= pio_pkg::INIT_RST;
        end
        else
        begin
            out_q       <= out_d;
            dir_q       <= dir_d;
            od_q        <= od_d;
            alt_q       <= alt_d;
            pad_q       <= pad_d;
            thr_q       <= thr_d;
            init_done_q <= init_done_d;
        end
    end

    // Pad shaping straight from the registers
    assign pad_driver_control = pad_q;

    // Threshold select only where the port has it
    always_comb
    begin
        // Ports without it report TTL
        for (int p = 0; p < pio_pkg::NPORT; p++)
            threshold_sel[p] = pio_pkg::THR_CAP[p] ? thr_q[p] : 2'h0;
    end

    // ************************************************************
    // Output stages
    // ************************************************************

    // Reset forcing is asynchronous so lines float before any edge
    for (genvar g = 0; g < pio_pkg::NBIDIR; g++)
    begin : g_pad
        pio_pad #(
            .W      (pio_pkg::PW),
            .MASK   (pio_pkg::PORT_MASK[g]),
            .HAS_OD (pio_pkg::OD_CAP[g]),
            // Only P20 keeps a line driven
            .KEEP   ((g == pio_pkg::P20_IDX) ? pio_pkg::P20_KEEP_MASK : 16'h0000)
        ) u_pad (
            .out_val  (out_q[g]),
            .dir      (dir_q[g]),
            .od       (od_q[g]),
            .alt_en   (alt_q[g]),
            .alt_out  (alt_out[g]),
            .alt_oe   (alt_oe[g]),
            .force_in (!presetn),
            .keep_val (init_done_q),
            .pin_out  (pin_out[g]),
            .pin_oe_n (pin_oe_n[g])
        );
    end

endmodule

//--- include/pio_pkg.sv
// Constants, address map and reset values of the parallel port block.
// Assumes an APB slave at the top and seven ports packed as 16-bit slices.
package pio_pkg;

    // ************************************************************
    // Port geometry
    // ************************************************************
    localparam int NPORT  = 7;      // Index 6 is the input-only port
    localparam int NBIDIR = 6;
    localparam int PW     = 16;

    // Index order: P0, P1, P3, P4, P9, P20, P5 (input only); 79 lines in all
    localparam logic [6:0][15:0] PORT_MASK = {16'h01ff, 16'h003f, 16'h00ff, 16'h00ff,
                                              16'hffff, 16'hffff, 16'hffff};
    localparam logic [6:0] OD_CAP  = 7'h3c;  // P3, P4, P9, P20
    localparam logic [6:0] THR_CAP = 7'h1c;  // P3, P4, P9

    // Port 20 line assignment
    localparam int P20_IDX                     = 5;
    localparam int P20_READ_STROBE_BIT         = 0;
    localparam int P20_WRITE_STROBE_LOW_BIT    = 1;
    localparam int P20_ADDR_LATCH_BIT          = 2;
    localparam int P20_EXTERNAL_ACCESS_BIT     = 3;
    localparam int P20_RESET_INDICATION_BIT    = 4;
    localparam logic [15:0] P20_KEEP_MASK      = 16'h0010;

    // ************************************************************
    // Address map: byte address = port * 0x40 + register * 4
    // ************************************************************
    localparam int ADDR_PORT_LSB = 6;
    localparam int ADDR_REG_LSB  = 2;
    localparam logic [2:0] CTRL_PORT = 3'h7;
    localparam logic [3:0] REG_OUT  = 4'h0;
    localparam logic [3:0] REG_DIR  = 4'h1;
    localparam logic [3:0] REG_OD   = 4'h2;
    localparam logic [3:0] REG_IN   = 4'h3;
    localparam logic [3:0] REG_SET  = 4'h4;
    localparam logic [3:0] REG_CLR  = 4'h5;
    localparam logic [3:0] REG_ALT  = 4'h6;
    localparam logic [3:0] REG_PAD  = 4'h7;
    localparam logic [3:0] REG_THR  = 4'h8;
    localparam logic [3:0] REG_CTRL = 4'h0;  // At port slot 7

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] OUT_RST  = 16'h0000;
    localparam logic [15:0] DIR_RST  = 16'h0000;
    localparam logic [15:0] OD_RST   = 16'h0000;
    localparam logic [15:0] ALT_RST  = 16'h0000;
    localparam logic [3:0]  PAD_RST  = 4'h0;
    localparam logic [1:0]  THR_RST  = 2'h0;
    localparam logic        INIT_RST = 1'b0;

endpackage

//--- tb/parallel_io_ports_tb.sv
// Self-checking bench for pio_top: APB master, pin model, random port traffic.
// Assumes pio_pkg, the pin model and the checker are compiled first.
`timescale 1ns/1ns
module parallel_io_ports_tb;
    logic             pclk;
    logic             presetn;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [11:0]      paddr;
    logic [31:0]      pwdata;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
    logic             external_access_enable;
    logic [6:0][15:0] pin_in, alt_in, ext_val, ext_en;
    logic [5:0][15:0] pin_out, pin_oe_n, alt_out, alt_oe;
    logic [5:0][3:0]  pad_driver_control;
    logic [6:0][1:0]  threshold_sel;
    logic [15:0]      s_out[6], s_dir[6], s_od[6], s_alt[6];
    logic             s_init;
    int               n_mismatch, samples_checked, seed;

    pio_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
        .pad_driver_control(pad_driver_control), .threshold_sel(threshold_sel),
        .external_access_enable(external_access_enable));
    pio_pin_model u_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));

    // 50 MHz clock
    always #10 pclk = ~pclk;

    // ****************************************
    // Bus tasks and expectations
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Request held until pready is seen; no latency is assumed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) check(16'h0, 16'h1, "no ready");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {16'h0, d}, r, e);
        check(16'(e), 16'h0, "write refused");
    endtask

    task automatic rd(input logic [11:0] a, input logic [15:0] x, input logic xe = 1'b0);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r[15:0], x, "read data");
        check(r[31:16] | 16'(e), 16'(xe), "read upper or error");
    endtask

    function automatic logic [11:0] ra(int p, logic [3:0] g);
        return {3'h0, p[2:0], g, 2'h0};
    endfunction

    function automatic logic [127:0] wide();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction

    // Open-drain lines holding a 1 float; the reset indication always drives
    function automatic logic [15:0] e_oen(int p);
        logic [15:0] drv;
        drv = (s_alt[p] & alt_oe[p]) | (~s_alt[p] & s_dir[p] & ~(s_od[p] & s_out[p]));
        if (p == 5) drv = drv | pio_pkg::P20_KEEP_MASK;
        return ~(drv & pio_pkg::PORT_MASK[p]);
    endfunction

    function automatic logic [15:0] e_val(int p);
        logic [15:0] v;
        if (p > 5) return 16'h0;
        v = (s_alt[p] & alt_out[p]) | (~s_alt[p] & s_out[p]);
        if (p == 5) v[4] = s_init;
        return v;
    endfunction

    function automatic logic [15:0] lvl(int p);
        logic [15:0] oen;
        oen = (p < 6) ? e_oen(p) : 16'hffff;
        return ((~oen & e_val(p)) | (oen & ~(ext_en[p] & ~ext_val[p]))) & pio_pkg::PORT_MASK[p];
    endfunction

    // One random pass over a port: registers, pins, peripherals, board
    task automatic step(int p);
        logic [15:0] m, v, l;
        logic [3:0]  pd;
        m = pio_pkg::PORT_MASK[p];
        s_out[p] = 16'(wide()) & m;
        wr(ra(p, pio_pkg::REG_OUT), s_out[p]);
        v = 16'(wide());
        wr(ra(p, pio_pkg::REG_SET), v);
        s_out[p] = s_out[p] | (v & m);
        rd(ra(p, pio_pkg::REG_OUT), s_out[p]);
        v = 16'(wide());
        wr(ra(p, pio_pkg::REG_CLR), v);
        s_out[p] = s_out[p] & ~v;
        rd(ra(p, pio_pkg::REG_OUT), s_out[p]);
        s_dir[p] = 16'(wide()) & m;
        wr(ra(p, pio_pkg::REG_DIR), s_dir[p]);
        rd(ra(p, pio_pkg::REG_DIR), s_dir[p]);
        s_alt[p] = 16'(wide()) & m & ~((p == 5) ? pio_pkg::P20_KEEP_MASK : 16'h0);
        wr(ra(p, pio_pkg::REG_ALT), s_alt[p]);
        if (pio_pkg::OD_CAP[p])
        begin
            s_od[p] = 16'(wide()) & m & ~s_alt[p];
            wr(ra(p, pio_pkg::REG_OD), s_od[p]);
        end
        pd = 4'(wide());
        wr(ra(p, pio_pkg::REG_PAD), {12'h0, pd});
        if (pio_pkg::THR_CAP[p]) wr(ra(p, pio_pkg::REG_THR), {14'h0, pd[1:0]});
        alt_out <= 96'(wide());
        alt_oe <= 96'(wide());
        ext_val <= 112'(wide());
        ext_en <= 112'(wide());
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        l = lvl(p);
        check(pin_oe_n[p], e_oen(p), "enable");
        check(pin_out[p] & ~e_oen(p), e_val(p) & ~e_oen(p), "level");
        check(alt_in[p], l, "synced pin");
        check(16'(pad_driver_control[p]), 16'(pd), "pad");
        if (pio_pkg::THR_CAP[p]) check(16'(threshold_sel[p]), 16'(pd[1:0]), "thr");
        if (p == 5) check(16'(external_access_enable), 16'(l[3]), "access");
        rd(ra(p, pio_pkg::REG_IN), l);
        rd(ra(6, pio_pkg::REG_IN), lvl(6));
    endtask

    // Reset: all lines floating but the reset indication, held low
    task automatic in_reset();
        @(negedge pclk);
        for (int p = 0; p < 6; p++)
            check(pin_oe_n[p], (p == 5) ? 16'hffef : 16'hffff, "reset enable");
        check(pin_out[5] & 16'h0010, 16'h0, "reset indication");
        for (int p = 0; p < 6; p++)
        begin
            s_out[p] = 16'h0;
            s_dir[p] = 16'h0;
            s_od[p] = 16'h0;
            s_alt[p] = 16'h0;
        end
        s_init = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int p = 0; p < 6; p++)
            for (int g = 0; g < 9; g++)
                if (g inside {0, 1, 6, 7} || (g == 2 && pio_pkg::OD_CAP[p]) ||
                    (g == 8 && pio_pkg::THR_CAP[p]))
                    rd(ra(p, 4'(g)), 16'h0);
        rd(12'h1c0, 16'h0);
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        alt_out = '0;
        alt_oe = '0;
        ext_val = '0;
        ext_en = '0;
        n_mismatch = 0;
        samples_checked = 0;
        seed = 19;
        in_reset();
        rd(12'h1c4, 16'h0, 1'b1);
        rd(12'h002, 16'h0, 1'b1);
        rd(12'h200, 16'h0, 1'b1);
        for (int i = 0; i < 24; i++) step(i % 6);
        wr(12'h1c0, 16'h1);
        s_init = 1'b1;
        rd(12'h1c0, 16'h1);
        step(5);
        presetn <= 1'b0;
        in_reset();
        step(5);
        for (int i = 0; i < 12; i++) step(int'(16'(wide())) % 6);
        report_and_stop();
    end

    // Well above the few thousand cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end
endmodule

//--- tb/pio_pin_model.sv
// Pin-side partner: resolves every pad from the block drive and a board source.
// Assumes a pull-up on every line; the bench sets the board source.
`timescale 1ns/1ns
module pio_pin_model (
    input  wire logic [5:0][15:0] pin_out,
    input  wire logic [5:0][15:0] pin_oe_n,
    input  wire logic [6:0][15:0] ext_val,
    input  wire logic [6:0][15:0] ext_en,
    output logic      [6:0][15:0] pin_in
);
    // Block drive wins; undriven lines rise to the pull-up level
    always_comb
    begin
        pin_in = ~(ext_en & ~ext_val);
        for (int p = 0; p < 6; p++)
            pin_in[p] = (pin_oe_n[p] & pin_in[p]) | (~pin_oe_n[p] & pin_out[p]);
    end
endmodule

//--- tb/pio_top_props.sv
// Concurrent checks on the ports of the parallel port block.
// Assumes one clock, pclk, and asynchronous active-low presetn.
`timescale 1ns/1ns
module pio_top_props (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic             pready,
    input wire logic [31:0]      prdata,
    input wire logic             pslverr,
    input wire logic [6:0][15:0] pin_in,
    input wire logic [5:0][15:0] pin_out,
    input wire logic [5:0][15:0] pin_oe_n,
    input wire logic [6:0][15:0] alt_in,
    input wire logic [5:0][3:0]  pad_driver_control,
    input wire logic [6:0][1:0]  threshold_sel,
    input wire logic             external_access_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Only the reset indication line may drive while reset is low
    localparam logic [5:0][15:0] OE_RST = {16'hffef, {5{16'hffff}}};
    logic       done;
    logic [1:0] up_q;
    logic [1:0] up_d;
    // Age since reset, so two-deep history never looks into reset
    assign done = psel && penable && pready;
    always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            up_q <= 2'h0;
        else
            up_q <= up_d;

    chk_rst_inputs: assert property (disable iff (1'b0)
        !presetn |-> pin_oe_n == OE_RST && !pin_out[5][4])
        else $error("line driven during reset");
    chk_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("answer not after one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    chk_misalign_err: assert property (done && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access accepted");
    chk_sync_delay: assert property (up_q == 2'h3 |->
        alt_in == ($past(pin_in, 2) & pio_pkg::PORT_MASK))
        else $error("pin sample not two cycles old");
    chk_ea_sync: assert property (up_q == 2'h3 |->
        external_access_enable == $past(pin_in[5][3], 2))
        else $error("access enable not synchronised");
    chk_idle_lines: assert property (&(pin_oe_n | pio_pkg::PORT_MASK[5:0]))
        else $error("line beyond port width driven");
    chk_pad_cause: assert property ($changed(pad_driver_control) |->
        $past(done && pwrite))
        else $error("pad control changed without write");
    chk_thr_cause: assert property ($changed(threshold_sel) |->
        $past(done && pwrite))
        else $error("threshold changed without write");
    chk_thr_absent: assert property (threshold_sel[1:0] == 4'h0 &&
        threshold_sel[6:5] == 4'h0)
        else $error("threshold set on port without it");

    cov_write: cover property (done && pwrite);
    cov_refused: cover property (done && pslverr);
    cov_init_high: cover property (!pin_oe_n[5][4] && pin_out[5][4]);
endmodule

bind pio_top pio_top_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .alt_in(alt_in), .pad_driver_control(pad_driver_control),
    .threshold_sel(threshold_sel), .external_access_enable(external_access_enable));
